// ==== hw/its_pkg.sv ====
// Constants, stamp layout and state codes for isochronous timestamp arithmetic
// How it works
// [R1] Cycle offset advances each 24.576 MHz tick
// [R2] Cycle offset wraps after 3071 to zero
// [R3] Transmit offset sum over 3071 carries, minus 3072
// [R4] Cycle count wraps after 7999, seconds increment
// [R5] Transmit count sum over 7999 carries, minus 8000
// [R6] Out-of-range transmit offset fields clamp to maximum
// [R7] No other correction of transmit offset fields
// [R8] Received stamp plus receive offset forms new stamp
// [R9] Held packet released when adjusted stamp matches timer
// [R10] Receive aging discards packets older than timer
// [R11] Receive offset unchecked; host keeps fields legal
// [R12] Transmit stamp is timer plus transmit offset
// [R13] Transmit seconds offset added only when extended enabled; receive path always adds it
// [R14] Separate transmit and receive aging enables
// [R15] Seconds 0-6, count 7-19, offset 20-31
// [R16] Seconds field wraps from 127 to zero
package its_pkg;

  // ----------------------------------------------------------------
  // Clock rates and tick generation
  // ----------------------------------------------------------------
  localparam int unsigned CLK_RATE_KHZ  = 40000;  // ref_clk rate
  localparam int unsigned TICK_RATE_KHZ = 24576;  // Cycle timer rate
  localparam logic [15:0] TICK_MOD      = 16'(CLK_RATE_KHZ);
  localparam logic [15:0] TICK_STEP     = 16'(TICK_RATE_KHZ);
  localparam logic [15:0] TICK_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Stamp field layout
  // ----------------------------------------------------------------
  localparam int SEC_LSB = 0;   // Seconds count
  localparam int SEC_W   = 7;
  localparam int CNT_LSB = 7;   // Cycle count
  localparam int CNT_W   = 13;
  localparam int OFF_LSB = 20;  // Cycle offset
  localparam int OFF_W   = 12;

  // ----------------------------------------------------------------
  // Field limits and reset value
  // ----------------------------------------------------------------
  localparam logic [OFF_W-1:0] OFF_MAX     = 12'hBFF;   // 3071
  localparam logic [OFF_W:0]   OFF_SPAN    = 13'h0C00;  // 3072
  localparam logic [CNT_W-1:0] CNT_MAX     = 13'h1F3F;  // 7999
  localparam logic [CNT_W:0]   CNT_SPAN    = 14'h1F40;  // 8000
  localparam logic [31:0]      STAMP_RESET = 32'h00000000;

  // Offset field at bits 31..20, count at 19..7, seconds at 6..0
  typedef struct packed {
    logic [OFF_W-1:0] off;
    logic [CNT_W-1:0] cnt;
    logic [SEC_W-1:0] sec;
  } its_stamp_s;

  // Receive hold state, one-hot
  typedef enum logic [1:0] {
    ITS_RX_IDLE = 2'b01,
    ITS_RX_HOLD = 2'b10
  } its_rx_e;

endpackage

// ==== hw/its_sum_if.sv ====
// Operand and result bundle between the timer logic and a stamp adder
`timescale 1ns/1ps
`default_nettype none
interface its_sum_if;
  import its_pkg::*;

  its_stamp_s base;      // Timer or captured stamp
  its_stamp_s addend;    // Programmed offset
  logic       clamp_en;  // Clamp offset and count fields
  logic       sec_en;    // Add the seconds field too
  its_stamp_s sum;       // Corrected sum

  modport adder (input base, addend, clamp_en, sec_en, output sum);
  modport user  (output base, addend, clamp_en, sec_en, input sum);
endinterface
`default_nettype wire

// ==== hw/its_stamp_add.sv ====
// Field-wise stamp adder with carry and modulo correction
`timescale 1ns/1ps
`default_nettype none
module its_stamp_add (
  its_sum_if.adder sif  // Operands in, corrected sum out
);
  import its_pkg::*;

  // ----------------------------------------------------------------
  // Offset field limiting
  // ----------------------------------------------------------------
  wire logic             off_big;
  wire logic             cnt_big;
  wire logic [OFF_W-1:0] off_add;
  wire logic [CNT_W-1:0] cnt_add;
  wire logic [SEC_W-1:0] sec_add;

  // Only cycle offset and count are limited, nothing else touched
  assign off_big = sif.addend.off > OFF_MAX;
  assign cnt_big = sif.addend.cnt > CNT_MAX;
  assign off_add = (sif.clamp_en && off_big) ? OFF_MAX : sif.addend.off;  // [R6] [R7]
  assign cnt_add = (sif.clamp_en && cnt_big) ? CNT_MAX : sif.addend.cnt;  // [R6] [R7]
  assign sec_add = sif.sec_en ? sif.addend.sec : '0;                       // [R13]

  // ----------------------------------------------------------------
  // Cycle offset sum
  // ----------------------------------------------------------------
  wire logic [OFF_W:0] off_raw;
  wire logic           off_carry;
  wire logic [OFF_W:0] off_fix;

  assign off_raw   = {1'b0, sif.base.off} + {1'b0, off_add};
  assign off_carry = off_raw > {1'b0, OFF_MAX};                  // [R3]
  assign off_fix   = off_carry ? (off_raw - OFF_SPAN) : off_raw; // [R3]

  // ----------------------------------------------------------------
  // Cycle count sum, fed by the offset carry
  // ----------------------------------------------------------------
  wire logic [CNT_W:0] cnt_raw;
  wire logic           cnt_carry;
  wire logic [CNT_W:0] cnt_fix;

  assign cnt_raw   = {1'b0, sif.base.cnt} + {1'b0, cnt_add} + {{CNT_W{1'b0}}, off_carry};
  assign cnt_carry = cnt_raw > {1'b0, CNT_MAX};                  // [R5]
  assign cnt_fix   = cnt_carry ? (cnt_raw - CNT_SPAN) : cnt_raw; // [R5]

  // ----------------------------------------------------------------
  // Seconds sum, modulo 128 by width
  // ----------------------------------------------------------------
  wire logic [SEC_W-1:0] sec_fix;

  assign sec_fix = sif.base.sec + sec_add + {{(SEC_W-1){1'b0}}, cnt_carry};  // [R16]

  // One driver for the whole sum, fields packed in stamp order
  assign sif.sum = {off_fix[OFF_W-1:0], cnt_fix[CNT_W-1:0], sec_fix};  // [R15]
endmodule
`default_nettype wire

// ==== hw/its_timestamp.sv ====
// Cycle timer, transmit stamping, receive hold and aging
`timescale 1ns/1ps
`default_nettype none
module its_timestamp (
  input  wire logic        ref_clk,               // 40 MHz clock
  input  wire logic        rst_b,                 // Async reset, low
  input  wire logic [31:0] transmit_time_offset,  // Offset for sent stamps
  input  wire logic [31:0] receive_time_offset,   // Offset for received stamps
  input  wire logic        ext_offset_en,         // Add seconds of offset
  input  wire logic        tx_aging_en,           // Transmit aging on
  input  wire logic        rx_aging_en,           // Receive aging on
  input  wire logic        tx_req,                // Stamp request pulse
  input  wire logic        rx_valid,              // Received stamp strobe
  input  wire logic [31:0] rx_stamp,              // Received stamp
  input  wire logic        tx_age_valid,          // Waiting packet check
  input  wire logic [31:0] tx_age_stamp,          // Waiting packet stamp
  output logic      [31:0] cycle_timer,           // Running timer
  output logic             timer_tick,            // Timer advances on next clock
  output logic      [31:0] tx_stamp,              // Stamp for sending
  output logic             tx_stamp_valid,        // Stamp ready pulse
  output logic             rx_ready,              // Free to take a packet
  output logic      [31:0] rx_hold_stamp,         // Adjusted held stamp
  output logic             rx_release,            // Release pulse
  output logic             rx_discard,            // Expired packet pulse
  output logic             tx_age_done,           // Check done pulse
  output logic             tx_age_stale           // Packet too old
);
  import its_pkg::*;

  // ----------------------------------------------------------------
  // Tick generator
  // ----------------------------------------------------------------
  // A phase accumulator makes 24576 ticks out of 40000 clocks, so
  // the tick rate is exact on average and jitters by one clock.
  logic [15:0] phase_q;
  logic [15:0] phase_d;
  logic        tick_q;
  wire  logic  tick_hit;
  wire  logic [15:0] phase_sum;

  assign phase_sum = phase_q + TICK_STEP;
  assign tick_hit  = phase_sum >= TICK_MOD;
  assign phase_d   = tick_hit ? (phase_sum - TICK_MOD) : phase_sum;

  // Phase and tick registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= TICK_RESET;
      tick_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tick_q  <= tick_hit;
    end
  end

  // ----------------------------------------------------------------
  // Cycle timer
  // ----------------------------------------------------------------
  its_stamp_s timer_q;
  its_stamp_s timer_d;
  wire logic  off_end;
  wire logic  cnt_end;
  wire logic [OFF_W-1:0] off_next;
  wire logic [CNT_W-1:0] cnt_next;
  wire logic [SEC_W-1:0] sec_next;

  // Field wrap points
  assign off_end  = timer_q.off == OFF_MAX;                           // [R2]
  assign cnt_end  = timer_q.cnt == CNT_MAX;                           // [R4]
  assign off_next = off_end ? '0 : timer_q.off + 12'h001;             // [R1] [R2]
  assign cnt_next = cnt_end ? '0 : timer_q.cnt + 13'h0001;            // [R4]
  assign sec_next = timer_q.sec + 7'h01;                              // [R16]

  // Next timer value; count and seconds move only on offset wrap
  always_comb begin
    timer_d = timer_q;
    if (tick_q) begin
      timer_d.off = off_next;                                         // [R1]
      if (off_end) begin
        timer_d.cnt = cnt_next;
        if (cnt_end) begin
          timer_d.sec = sec_next;                                     // [R4] [R16]
        end
      end
    end
  end

  // Timer register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= STAMP_RESET;
    end else begin
      timer_q <= timer_d;
    end
  end

  // ----------------------------------------------------------------
  // Stamp ordering
  // ----------------------------------------------------------------
  // Seconds are most significant, then count, then offset. The key
  // does not look across a seconds wrap.
  function automatic logic [31:0] age_key(input its_stamp_s s);
    age_key = {s.sec, s.cnt, s.off};
  endfunction

  wire logic [31:0] timer_key;

  assign timer_key = age_key(timer_q);

  // ----------------------------------------------------------------
  // Transmit stamp adder
  // ----------------------------------------------------------------
  its_sum_if tx_sif ();

  // Timer plus offset, fields clamped, seconds only when extended
  assign tx_sif.base     = timer_q;                                   // [R12]
  assign tx_sif.addend   = transmit_time_offset;                      // [R12] [R15]
  assign tx_sif.clamp_en = 1'b1;                                      // [R6]
  assign tx_sif.sec_en   = ext_offset_en;                             // [R13]

  its_stamp_add u_tx_add (
    .sif (tx_sif.adder)
  );

  // ----------------------------------------------------------------
  // Transmit stamp output
  // ----------------------------------------------------------------
  logic [31:0] tx_stamp_q;
  logic        tx_stamp_valid_q;

  // Stamp is taken on the request edge and held until the next one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_stamp_q       <= STAMP_RESET;
      tx_stamp_valid_q <= 1'b0;
    end else begin
      tx_stamp_valid_q <= tx_req;
      if (tx_req) begin
        tx_stamp_q <= tx_sif.sum;                                     // [R12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit aging check
  // ----------------------------------------------------------------
  logic        tx_age_done_q;
  logic        tx_age_stale_q;
  wire  logic  tx_is_old;

  // A waiting packet is stale when its stamp is behind the timer
  assign tx_is_old = age_key(its_stamp_s'(tx_age_stamp)) < timer_key;

  // Check result registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_age_done_q  <= 1'b0;
      tx_age_stale_q <= 1'b0;
    end else begin
      tx_age_done_q <= tx_age_valid;
      if (tx_age_valid) begin
        tx_age_stale_q <= tx_aging_en && tx_is_old;                   // [R14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive stamp adder
  // ----------------------------------------------------------------
  its_sum_if rx_sif ();

  // Receive offset is used as given; no clamping on this path
  assign rx_sif.base     = rx_stamp;                                  // [R8] [R15]
  assign rx_sif.addend   = receive_time_offset;                       // [R8]
  assign rx_sif.clamp_en = 1'b0;                                      // [R11]
  assign rx_sif.sec_en   = 1'b1;

  its_stamp_add u_rx_add (
    .sif (rx_sif.adder)
  );

  // ----------------------------------------------------------------
  // Receive hold state machine
  // ----------------------------------------------------------------
  its_rx_e    rx_state_q;
  its_rx_e    rx_state_d;
  its_stamp_s rx_adj_q;
  logic       rx_release_q;
  logic       rx_discard_q;
  wire  logic rx_take;
  wire  logic rx_match;
  wire  logic rx_expired;
  wire  logic rx_hit;
  wire  logic rx_drop;

  // Decode of the held packet's fate
  assign rx_take    = (rx_state_q == ITS_RX_IDLE) && rx_valid;
  assign rx_match   = rx_adj_q == timer_q;                            // [R9]
  assign rx_expired = age_key(rx_adj_q) < timer_key;                  // [R10]
  assign rx_hit     = (rx_state_q == ITS_RX_HOLD) && rx_match;        // [R9]
  assign rx_drop    = (rx_state_q == ITS_RX_HOLD) && !rx_match &&
                      rx_aging_en && rx_expired;                      // [R10] [R14]

  // Next state: match releases, aging drops, else keep holding
  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      ITS_RX_IDLE: begin
        if (rx_valid) begin
          rx_state_d = ITS_RX_HOLD;
        end
      end
      ITS_RX_HOLD: begin
        if (rx_hit || rx_drop) begin
          rx_state_d = ITS_RX_IDLE;
        end
      end
      default: begin
        rx_state_d = ITS_RX_IDLE;
      end
    endcase
  end

  // State and held stamp registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_q <= ITS_RX_IDLE;
      rx_adj_q   <= STAMP_RESET;
    end else begin
      rx_state_q <= rx_state_d;
      if (rx_take) begin
        rx_adj_q <= rx_sif.sum;                                       // [R8]
      end
    end
  end

  // Release and discard pulses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_release_q <= 1'b0;
      rx_discard_q <= 1'b0;
    end else begin
      rx_release_q <= rx_hit;                                         // [R9]
      rx_discard_q <= rx_drop;                                        // [R10]
    end
  end

  // Ready mirrors the next state so it stays a flop output
  logic rx_ready_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= rx_state_d == ITS_RX_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cycle_timer    = timer_q;
  assign timer_tick     = tick_q;
  assign tx_stamp       = tx_stamp_q;
  assign tx_stamp_valid = tx_stamp_valid_q;
  assign rx_ready       = rx_ready_q;
  assign rx_hold_stamp  = rx_adj_q;
  assign rx_release     = rx_release_q;
  assign rx_discard     = rx_discard_q;
  assign tx_age_done    = tx_age_done_q;
  assign tx_age_stale   = tx_age_stale_q;
endmodule
`default_nettype wire

// ==== test/its_timestamp_chk.sv ====
// Concurrent checks on the ports of the timestamp block
`timescale 1ns/1ps
`default_nettype none
module its_timestamp_chk (
  input wire logic        ref_clk,         // Clock
  input wire logic        rst_b,           // Async reset, low
  input wire logic        rx_aging_en,     // Receive aging on
  input wire logic        tx_aging_en,     // Transmit aging on
  input wire logic        tx_req,          // Stamp request
  input wire logic        tx_age_valid,    // Age check request
  input wire logic [31:0] tx_age_stamp,    // Stamp to age
  input wire logic [31:0] cycle_timer,     // Running timer
  input wire logic        timer_tick,      // Timer advance
  input wire logic [31:0] tx_stamp,        // Sent stamp
  input wire logic        tx_stamp_valid,  // Stamp ready
  input wire logic        rx_ready,        // Hold idle
  input wire logic [31:0] rx_hold_stamp,   // Held stamp
  input wire logic        rx_release,      // Release pulse
  input wire logic        rx_discard,      // Discard pulse
  input wire logic        tx_age_done,     // Age check done
  input wire logic        tx_age_stale     // Packet too old
);
  import its_pkg::*;

  // Order key: seconds, then count, then offset
  function automatic logic [31:0] f_key(input logic [31:0] t);
    return {t[6:0], t[19:7], t[31:20]};
  endfunction

  // Timer value one tick later
  function automatic logic [31:0] f_inc(input logic [31:0] t);
    logic [11:0] o;
    logic [12:0] c;
    logic [6:0]  s;
    o = t[31:20] + 12'h001;
    c = t[19:7];
    s = t[6:0];
    if (t[31:20] == 12'hBFF) begin
      o = 12'h000;
      c = (c == 13'h1F3F) ? 13'h0000 : c + 13'h0001;
      s = (t[19:7] == 13'h1F3F) ? s + 7'h01 : s;
    end
    return {o, c, s};
  endfunction

  logic seen_q;  // Hold has been idle since reset
  wire logic held = seen_q && !rx_ready;
  wire logic late = f_key(rx_hold_stamp) < f_key(cycle_timer);

  // Keeps the reset-time low of rx_ready from counting as a hold
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_q | rx_ready;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_match;
    held && rx_hold_stamp == cycle_timer;
  endsequence
  sequence s_stale;
    held && rx_hold_stamp != cycle_timer && rx_aging_en && late;
  endsequence
  sequence s_wait;
    held && rx_hold_stamp != cycle_timer && !(rx_aging_en && late);
  endsequence

  a_tick_advance: assert property (
    timer_tick |=> cycle_timer == f_inc($past(cycle_timer))) else $error("timer step wrong");
  a_timer_hold: assert property (!timer_tick |=> $stable(cycle_timer)) else $error("timer moved");
  a_off_legal: assert property (cycle_timer[31:20] <= 12'hBFF) else $error("timer offset over");
  a_tx_answer: assert property (tx_req |=> tx_stamp_valid) else $error("no stamp");
  a_tx_quiet: assert property (!tx_req |=> !tx_stamp_valid && $stable(tx_stamp)) else $error("stray stamp");
  a_tx_fields: assert property (
    tx_stamp_valid |-> tx_stamp[31:20] <= 12'hBFF && tx_stamp[19:7] <= 13'h1F3F) else $error("stamp field over");
  a_age_answer: assert property (tx_age_valid |=> tx_age_done &&
    tx_age_stale == ($past(tx_aging_en) && f_key($past(tx_age_stamp)) < f_key($past(cycle_timer))))
    else $error("age check wrong");
  a_rx_release: assert property (s_match |=> rx_release && !rx_discard && rx_ready) else $error("no release");
  a_rx_discard: assert property (s_stale |=> rx_discard && !rx_release && rx_ready) else $error("no discard");
  a_rx_wait: assert property (s_wait |=> !rx_release && !rx_discard && !rx_ready) else $error("early out");
endmodule
`default_nettype wire

// ==== test/tb_its_timestamp.sv ====
// Self-checking bench for the timestamp block
`timescale 1ns/1ps
`default_nettype none
module tb_its_timestamp;
  import its_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] transmit_time_offset = 32'h00000000;
  logic [31:0] receive_time_offset = 32'h00000000;
  logic        ext_offset_en = 1'b0;
  logic        tx_aging_en = 1'b0;
  logic        rx_aging_en = 1'b0;
  logic        tx_req = 1'b0;
  logic        rx_valid = 1'b0;
  logic [31:0] rx_stamp = 32'h00000000;
  logic        tx_age_valid = 1'b0;
  logic [31:0] tx_age_stamp = 32'h00000000;
  logic [31:0] cycle_timer, tx_stamp, rx_hold_stamp;
  logic        timer_tick, tx_stamp_valid, rx_ready, rx_release, rx_discard, tx_age_done, tx_age_stale;
  int          fails = 0;
  int          n_checks = 0;
  int          cnt;
  logic [31:0] corner [4] = '{32'hFFFFFFFF, {12'hBFF, 13'h1F3F, 7'h7F}, {12'hC00, 13'h1F40, 7'h00}, 32'h00000000};

  its_timestamp dut (.ref_clk(ref_clk), .rst_b(rst_b), .transmit_time_offset(transmit_time_offset),
    .receive_time_offset(receive_time_offset), .ext_offset_en(ext_offset_en), .tx_aging_en(tx_aging_en),
    .rx_aging_en(rx_aging_en), .tx_req(tx_req), .rx_valid(rx_valid), .rx_stamp(rx_stamp),
    .tx_age_valid(tx_age_valid), .tx_age_stamp(tx_age_stamp), .cycle_timer(cycle_timer),
    .timer_tick(timer_tick), .tx_stamp(tx_stamp), .tx_stamp_valid(tx_stamp_valid), .rx_ready(rx_ready),
    .rx_hold_stamp(rx_hold_stamp), .rx_release(rx_release), .rx_discard(rx_discard),
    .tx_age_done(tx_age_done), .tx_age_stale(tx_age_stale));

  // 40 MHz clock
  initial forever #12.5 ref_clk = ~ref_clk;

  // Field-wise stamp sum with optional clamp and seconds add
  function automatic logic [31:0] f_sum(input logic [31:0] b, input logic [31:0] a, input logic cl, input logic se);
    logic [13:0] o;
    logic [14:0] n;
    logic [7:0]  s;
    o = {2'h0, a[31:20]};
    n = {2'h0, a[19:7]};
    if (cl && o > 14'h0BFF) o = 14'h0BFF;
    if (cl && n > 15'h1F3F) n = 15'h1F3F;
    o = o + {2'h0, b[31:20]};
    n = n + {2'h0, b[19:7]};
    s = {1'b0, b[6:0]} + (se ? {1'b0, a[6:0]} : 8'h00);
    if (o > 14'h0BFF) begin
      o = o - 14'h0C00;
      n = n + 15'h0001;
    end
    if (n > 15'h1F3F) begin
      n = n - 15'h1F40;
      s = s + 8'h01;
    end
    return {o[11:0], n[12:0], s[6:0]};
  endfunction

  function automatic logic [31:0] f_key(input logic [31:0] t);
    return {t[6:0], t[19:7], t[31:20]};
  endfunction

  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  // One transmit stamp against the timer seen at the taking edge
  task automatic tx_one(input logic [31:0] off, input logic ext);
    logic [31:0] t;
    @(posedge ref_clk);
    transmit_time_offset <= off;
    ext_offset_en <= ext;
    tx_req <= 1'b1;
    @(negedge ref_clk);
    t = cycle_timer;
    @(posedge ref_clk);
    tx_req <= 1'b0;
    @(negedge ref_clk);
    check("tx_stamp_valid", 32'(tx_stamp_valid), 32'h1);
    check("tx_stamp", tx_stamp, f_sum(t, off, 1'b1, ext));
  endtask

  task automatic age_one(input logic [31:0] st, input logic en);
    logic [31:0] t;
    @(posedge ref_clk);
    tx_age_stamp <= st;
    tx_aging_en <= en;
    tx_age_valid <= 1'b1;
    @(negedge ref_clk);
    t = cycle_timer;
    @(posedge ref_clk);
    tx_age_valid <= 1'b0;
    @(negedge ref_clk);
    check("tx_age_done", 32'(tx_age_done), 32'h1);
    check("tx_age_stale", 32'(tx_age_stale), 32'(en && f_key(st) < f_key(t)));
  endtask

  // Offer one packet; want 0 release, 1 discard, 2 still held
  task automatic rx_one(input logic [31:0] st, input logic [31:0] off, input logic ag, input int want);
    logic [1:0] got;
    @(posedge ref_clk);
    rx_stamp <= st;
    receive_time_offset <= off;
    rx_aging_en <= ag;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    got = 2'b00;
    for (int k = 0; k < 1000 && got == 2'b00 && !(want == 2 && k > 50); k++) begin
      @(negedge ref_clk);
      got = {rx_discard, rx_release};
    end
    check("rx_hold_stamp", rx_hold_stamp, f_sum(st, off, 1'b0, 1'b1));
    check("rx_outcome", 32'(got), (want == 0) ? 32'h1 : (want == 1) ? 32'h2 : 32'h0);
    check("rx_ready", 32'(rx_ready), (want == 2) ? 32'h0 : 32'h1);
    if (want < 2 && got == 2'b00) conclude();
  endtask

  initial begin
    void'($urandom(32'h8B86));
    do_reset();
    cnt = 0;
    repeat (4000) begin
      @(negedge ref_clk);
      cnt += int'(timer_tick === 1'b1);
    end
    check("tick_rate", 32'(cnt == 2457 || cnt == 2458), 32'h1);
    for (int i = 0; i < 8; i++) tx_one(corner[i % 4], 1'(i / 4));
    repeat (40) tx_one($urandom(), 1'($urandom()));
    repeat (20) age_one({12'($urandom_range(0, 3071)), 13'($urandom_range(0, 3)), 7'h00}, 1'($urandom()));
    repeat (4) begin
      @(negedge ref_clk);
      rx_one(cycle_timer, {12'($urandom_range(20, 400)), 13'h0000, 7'h00}, 1'($urandom()), 0);
    end
    rx_one(32'h00000000, 32'h00000000, 1'b1, 1);
    rx_one(32'h00000000, 32'h00000000, 1'b0, 2);
    // A second offer while a packet is held must be ignored
    @(posedge ref_clk);
    rx_stamp <= 32'hFFFFFFFF;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(negedge ref_clk);
    check("rx_refused", rx_hold_stamp, 32'h00000000);
    check("rx_ready_held", 32'(rx_ready), 32'h0);
    do_reset();
    @(negedge ref_clk);
    check("rx_ready_after_reset", 32'(rx_ready), 32'h1);
    check("timer_after_reset", cycle_timer, 32'h00000000);
    check("tx_stamp_after_reset", tx_stamp, 32'h00000000);
    conclude();
  end
endmodule

bind its_timestamp its_timestamp_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .rx_aging_en(rx_aging_en),
  .tx_aging_en(tx_aging_en), .tx_req(tx_req), .tx_age_valid(tx_age_valid), .tx_age_stamp(tx_age_stamp),
  .cycle_timer(cycle_timer), .timer_tick(timer_tick), .tx_stamp(tx_stamp), .tx_stamp_valid(tx_stamp_valid),
  .rx_ready(rx_ready), .rx_hold_stamp(rx_hold_stamp), .rx_release(rx_release), .rx_discard(rx_discard),
  .tx_age_done(tx_age_done), .tx_age_stale(tx_age_stale));
`default_nettype wire
